/* ppm_port_pin_mode_logic.sv */
// Port pin mode logic: port and mode registers, pin drive decode, reads and alternate functions.
// Assumes the CPU gives same-clock strobes and flags read-modify-write reads itself.
//
// How it works
// - Open-drain: no pull-ups, pull-down only while the port bit is 0.
// - Push-pull: strong pull-up while port bit is 1, pull-down while 0.
// - Quasi, open-drain and push-pull share one pull-down: on when bit low.
// - In power-down the port 3 bit 2 and 3 input buffers stay enabled.
// - Comparator enable forces port 1 bit 0 and 1 input buffers off.
// - Plain reads return the sampled pin levels.
// - Read-modify-write reads return the port register.
// - Alternate functions are ANDed with the pin's port register bit.
// - Fixed routing of comparator, SPI, UART, interrupt and timer functions.
// - Port 3 bit 6 follows the comparator output and has no mode.
// - Mode code {a,b}: 00 quasi, 01 push-pull, 10 input, 11 open-drain.
// - Reset places every pin in input-only mode.
// - Quasi mode: strong pull-up for one clock on a 0 to 1 port change.
module ppm_port_pin_mode_logic #(
    parameter int P1_W = ppm_pkg::P1_W,
    parameter int P3_W = ppm_pkg::P3_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Port register writes
    input wire logic port_wr_en,
    input wire logic port_wr_sel,
    input wire logic [7:0] port_wr_data,
    // Mode register writes
    input wire logic mode_wr_en,
    input wire logic mode_wr_sel,
    input wire logic [7:0] mode_wr_bit_a,
    input wire logic [7:0] mode_wr_bit_b,
    // Port reads
    input wire logic rd_en,
    input wire logic rd_sel,
    input wire logic rd_rmw,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Chip state
    input wire logic power_down,
    input wire logic comparator_enable,
    input wire logic comparator_out,
    // Peripheral outputs, 1 where a pin has none
    input wire logic [P1_W-1:0] p1_alt_out,
    input wire logic [P3_W-1:0] p3_alt_out,
    // Peripheral inputs
    output ppm_pkg::ppm_alt_in_t alt_in,
    // Pins
    input wire logic [P1_W-1:0] p1_pin_in,
    input wire logic [P3_W-1:0] p3_pin_in,
    output ppm_pkg::ppm_drive_t [P1_W-1:0] p1_drive,
    output ppm_pkg::ppm_drive_t [P3_W-1:0] p3_drive,
    // Mode readback
    output logic [P1_W+P3_W-1:0] pin_mode_bit_a,
    output logic [P1_W+P3_W-1:0] pin_mode_bit_b
);

    localparam int N = ppm_pkg::PIN_N;
    localparam int B = ppm_pkg::P3_BASE;

    if (P1_W != ppm_pkg::P1_W || P3_W != ppm_pkg::P3_W)
    begin : g_width_check
        $error("Port widths are fixed by the pin routing");
    end

    logic [N-1:0] port_reg;
    logic [N-1:0] port_next;
    logic [N-1:0] mode_a_reg;
    logic [N-1:0] mode_a_next;
    logic [N-1:0] mode_b_reg;
    logic [N-1:0] mode_b_next;
    logic [N-1:0] level;
    logic [N-1:0] level_prev_reg;
    logic [N-1:0] pin_sync;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    ppm_pkg::ppm_alt_in_t alt_in_reg;
    ppm_pkg::ppm_alt_in_t alt_in_next;
    ppm_pkg::ppm_drive_t [N-1:0] drive_reg;
    ppm_pkg::ppm_drive_t [N-1:0] drive_next;
    ppm_pkg::ppm_mode_t mode_vec [N];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ppm_sync #(
        .W(N)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in({p3_pin_in, p1_pin_in}),
        .sync_out(pin_sync)
    );

    // alternate output gated by port bit
    assign level = port_reg & {p3_alt_out, p1_alt_out};

    always_comb
    begin
        port_next = port_reg;
        mode_a_next = mode_a_reg;
        mode_b_next = mode_b_reg;
        if (port_wr_en)
        begin
            if (port_wr_sel == ppm_pkg::PORT_SEL_P1)
                port_next[B-1:0] = port_wr_data;
            else
                port_next[N-1:B] = port_wr_data[P3_W-1:0];
        end
        if (mode_wr_en)
        begin
            if (mode_wr_sel == ppm_pkg::PORT_SEL_P1)
            begin
                mode_a_next[B-1:0] = mode_wr_bit_a;
                mode_b_next[B-1:0] = mode_wr_bit_b;
            end
            else
            begin
                mode_a_next[N-1:B] = mode_wr_bit_a[P3_W-1:0];
                mode_b_next[N-1:B] = mode_wr_bit_b[P3_W-1:0];
            end
        end
    end

    always_comb
    begin
        rd_valid_next = rd_en;
        rd_data_next = rd_data_reg;
        if (rd_en)
        begin
            if (rd_rmw)
            begin
                if (rd_sel == ppm_pkg::PORT_SEL_P1)
                    rd_data_next = port_reg[B-1:0];
                else
                    rd_data_next = {1'b0, port_reg[N-1:B]};
            end
            else
            begin
                if (rd_sel == ppm_pkg::PORT_SEL_P1)
                    rd_data_next = pin_sync[B-1:0];
                else
                    rd_data_next = {1'b0, pin_sync[N-1:B]};
            end
        end
    end

    always_comb
    begin
        alt_in_next.comparator_input_plus_dig = pin_sync[ppm_pkg::IDX_CMP_PLUS] & port_reg[ppm_pkg::IDX_CMP_PLUS];
        alt_in_next.comparator_input_minus_dig = pin_sync[ppm_pkg::IDX_CMP_MINUS] & port_reg[ppm_pkg::IDX_CMP_MINUS];
        alt_in_next.spi_ss = pin_sync[ppm_pkg::IDX_SPI_SS] & port_reg[ppm_pkg::IDX_SPI_SS];
        alt_in_next.spi_mosi = pin_sync[ppm_pkg::IDX_SPI_MOSI] & port_reg[ppm_pkg::IDX_SPI_MOSI];
        alt_in_next.spi_miso = pin_sync[ppm_pkg::IDX_SPI_MISO] & port_reg[ppm_pkg::IDX_SPI_MISO];
        alt_in_next.spi_sck = pin_sync[ppm_pkg::IDX_SPI_SCK] & port_reg[ppm_pkg::IDX_SPI_SCK];
        alt_in_next.uart_rx = pin_sync[ppm_pkg::IDX_UART_RX] & port_reg[ppm_pkg::IDX_UART_RX];
        alt_in_next.external_interrupt_a_pin = pin_sync[ppm_pkg::IDX_EXT_INT_A] & port_reg[ppm_pkg::IDX_EXT_INT_A];
        alt_in_next.external_interrupt_b_pin = pin_sync[ppm_pkg::IDX_EXT_INT_B] & port_reg[ppm_pkg::IDX_EXT_INT_B];
        alt_in_next.timer_a_count_input = pin_sync[ppm_pkg::IDX_TIMER_A] & port_reg[ppm_pkg::IDX_TIMER_A];
        alt_in_next.timer_b_count_input = pin_sync[ppm_pkg::IDX_TIMER_B] & port_reg[ppm_pkg::IDX_TIMER_B];
    end

    for (genvar i = 0; i < N; i++)
    begin : g_pin
        assign mode_vec[i] = ppm_pkg::ppm_mode_t'({mode_a_reg[i], mode_b_reg[i]});

        ppm_pin_cell #(
            .WAKE_PIN(i == ppm_pkg::IDX_EXT_INT_A || i == ppm_pkg::IDX_EXT_INT_B),
            .ANALOG_PIN(i == ppm_pkg::IDX_CMP_PLUS || i == ppm_pkg::IDX_CMP_MINUS),
            .CMP_PIN(i == ppm_pkg::IDX_CMP_RESULT)
        ) u_cell (
            .mode(mode_vec[i]),
            .level(level[i]),
            .level_prev(level_prev_reg[i]),
            .pin_high(pin_sync[i]),
            .power_down(power_down),
            .comparator_enable(comparator_enable),
            .comparator_out(comparator_out),
            .drive(drive_next[i])
        );

        if (i != ppm_pkg::IDX_CMP_RESULT)
        begin : g_chk
            od_pins_off_a: assert property (mode_vec[i] == ppm_pkg::PPM_OPEN_DRAIN |=>
                !drive_reg[i].strong_up && !drive_reg[i].weak_up && !drive_reg[i].vweak_up
                && drive_reg[i].pull_down == !$past(level[i]))
                else $error("open-drain pin drove a pull-up or wrong pull-down");
            pp_strong_up_a: assert property (mode_vec[i] == ppm_pkg::PPM_PUSH_PULL && level[i] ##1
                mode_vec[i] == ppm_pkg::PPM_PUSH_PULL && level[i] |-> drive_reg[i].strong_up ##1 drive_reg[i].strong_up)
                else $error("push-pull pull-up not continuous");
            common_pull_down_a: assert property (mode_vec[i] != ppm_pkg::PPM_INPUT_ONLY |=>
                drive_reg[i].pull_down == !$past(level[i]))
                else $error("pull-down does not follow low port bit");
            quasi_kick_a: assert property (mode_vec[i] == ppm_pkg::PPM_QUASI && $rose(level[i])
                |=> drive_reg[i].strong_up
                ##1 (!drive_reg[i].strong_up || $past(mode_vec[i]) == ppm_pkg::PPM_PUSH_PULL))
                else $error("quasi strong pull-up not exactly one clock");
            input_hiz_a: assert property (mode_vec[i] == ppm_pkg::PPM_INPUT_ONLY |=>
                !drive_reg[i].strong_up && !drive_reg[i].weak_up && !drive_reg[i].vweak_up && !drive_reg[i].pull_down)
                else $error("input-only pin not high impedance");
            reset_input_a: assert property (@(posedge ref_clk) disable iff (1'b0) rst |=>
                mode_vec[i] == ppm_pkg::PPM_INPUT_ONLY)
                else $error("pin not input-only after reset");
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            port_reg <= ppm_pkg::PORT_RESET;
            mode_a_reg <= ppm_pkg::MODE_A_RESET;
            mode_b_reg <= ppm_pkg::MODE_B_RESET;
            level_prev_reg <= ppm_pkg::PORT_RESET;
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
            alt_in_reg <= '0;
            drive_reg <= '0;
        end
        else
        begin
            port_reg <= port_next;
            mode_a_reg <= mode_a_next;
            mode_b_reg <= mode_b_next;
            level_prev_reg <= level;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            alt_in_reg <= alt_in_next;
            drive_reg <= drive_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign alt_in = alt_in_reg;
    assign p1_drive = drive_reg[B-1:0];
    assign p3_drive = drive_reg[N-1:B];
    assign pin_mode_bit_a = mode_a_reg;
    assign pin_mode_bit_b = mode_b_reg;

    wake_ibuf_on_a: assert property (power_down |=>
        drive_reg[ppm_pkg::IDX_EXT_INT_A].input_buffer_power_enable
        && drive_reg[ppm_pkg::IDX_EXT_INT_B].input_buffer_power_enable
        && !drive_reg[ppm_pkg::IDX_UART_RX].input_buffer_power_enable)
        else $error("power-down input buffers wrong");

    analog_ibuf_off_a: assert property (comparator_enable |=>
        !drive_reg[ppm_pkg::IDX_CMP_PLUS].input_buffer_power_enable
        && !drive_reg[ppm_pkg::IDX_CMP_MINUS].input_buffer_power_enable)
        else $error("comparator pins kept digital input");

    pin_read_a: assert property (rd_en && !rd_rmw && rd_sel == ppm_pkg::PORT_SEL_P1 |=>
        rd_valid && rd_data == $past(pin_sync[B-1:0]))
        else $error("plain read did not return pins");

    rmw_read_a: assert property (rd_en && rd_rmw && rd_sel == ppm_pkg::PORT_SEL_P3 |=>
        rd_valid && rd_data == {1'b0, $past(port_reg[N-1:B])})
        else $error("read-modify-write did not return register");

    rd_pulse_a: assert property (!rd_en |=> !rd_valid)
        else $error("read valid without a read");

    rd_hold_a: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data changed without a read");

    alt_and_gate_a: assert property (!port_reg[ppm_pkg::IDX_EXT_INT_A] |=>
        !alt_in.external_interrupt_a_pin)
        else $error("alternate input not gated by port bit");

    alt_routing_a: assert property (port_reg[ppm_pkg::IDX_TIMER_B] |=>
        alt_in.timer_b_count_input == $past(pin_sync[ppm_pkg::IDX_TIMER_B]))
        else $error("timer input routed wrongly");

    cmp_pin_drive_a: assert property (1'b1 |=>
        drive_reg[ppm_pkg::IDX_CMP_RESULT].strong_up == $past(comparator_out)
        && drive_reg[ppm_pkg::IDX_CMP_RESULT].pull_down == !$past(comparator_out))
        else $error("comparator result pin not following comparator");

    od_low_c: cover property (mode_vec[3] == ppm_pkg::PPM_OPEN_DRAIN && !level[3] ##1 drive_reg[3].pull_down);
    quasi_kick_c: cover property (mode_vec[2] == ppm_pkg::PPM_QUASI && $rose(level[2]) ##1 drive_reg[2].strong_up);
    rmw_read_c: cover property (rd_en && rd_rmw ##1 rd_valid);
    pp_drive_c: cover property (mode_vec[5] == ppm_pkg::PPM_PUSH_PULL && level[5] ##1 drive_reg[5].strong_up);
    wake_pd_c: cover property (power_down ##1 drive_reg[ppm_pkg::IDX_EXT_INT_B].input_buffer_power_enable);

endmodule : ppm_port_pin_mode_logic

/* ppm_pkg.sv */
// Shared constants and types for the port pin mode logic.
// Assumes pins are numbered 0..7 for port 1 and 8..14 for port 3 bits 0..6.
package ppm_pkg;

    // Pin counts and the flat pin numbering
    localparam int P1_W = 8;
    localparam int P3_W = 7;
    localparam int PIN_N = 15;
    localparam int P3_BASE = 8;
    localparam int BYTE_W = 8;

    // Flat pin indices of the alternate functions
    localparam int IDX_CMP_PLUS = 0;
    localparam int IDX_CMP_MINUS = 1;
    localparam int IDX_SPI_SS = 4;
    localparam int IDX_SPI_MOSI = 5;
    localparam int IDX_SPI_MISO = 6;
    localparam int IDX_SPI_SCK = 7;
    localparam int IDX_UART_RX = 8;
    localparam int IDX_UART_TX = 9;
    localparam int IDX_EXT_INT_A = 10;
    localparam int IDX_EXT_INT_B = 11;
    localparam int IDX_TIMER_A = 12;
    localparam int IDX_TIMER_B = 13;
    localparam int IDX_CMP_RESULT = 14;

    // Reset values of the flat per-pin registers
    localparam logic [PIN_N-1:0] PORT_RESET = 15'h7fff;
    localparam logic [PIN_N-1:0] MODE_A_RESET = 15'h7fff;
    localparam logic [PIN_N-1:0] MODE_B_RESET = 15'h0000;

    // Port select on the write and read strobes
    localparam logic PORT_SEL_P1 = 1'b0;
    localparam logic PORT_SEL_P3 = 1'b1;

    // Mode code is {pin_mode_bit_a, pin_mode_bit_b}
    typedef enum logic [1:0] {
        PPM_QUASI = 2'b00,
        PPM_PUSH_PULL = 2'b01,
        PPM_INPUT_ONLY = 2'b10,
        PPM_OPEN_DRAIN = 2'b11
    } ppm_mode_t;

    typedef struct packed {
        logic strong_up;
        logic weak_up;
        logic vweak_up;
        logic pull_down;
        logic input_buffer_power_enable;
    } ppm_drive_t;

    typedef struct packed {
        logic comparator_input_plus_dig;
        logic comparator_input_minus_dig;
        logic spi_ss;
        logic spi_mosi;
        logic spi_miso;
        logic spi_sck;
        logic uart_rx;
        logic external_interrupt_a_pin;
        logic external_interrupt_b_pin;
        logic timer_a_count_input;
        logic timer_b_count_input;
    } ppm_alt_in_t;

endpackage : ppm_pkg

/* ppm_sync.sv */
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to ref_clk.
module ppm_sync #(
    parameter int W = 15
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule : ppm_sync

/* ppm_pin_cell.sv */
// Combinational drive decode for one port pin.
// Assumes level and level_prev come from ref_clk flops and pin_high is synchronised.
module ppm_pin_cell #(
    parameter bit WAKE_PIN = 1'b0,
    parameter bit ANALOG_PIN = 1'b0,
    parameter bit CMP_PIN = 1'b0
) (
    // Pin state
    input wire ppm_pkg::ppm_mode_t mode,
    input wire logic level,
    input wire logic level_prev,
    input wire logic pin_high,
    // Chip state
    input wire logic power_down,
    input wire logic comparator_enable,
    input wire logic comparator_out,
    // Result
    output ppm_pkg::ppm_drive_t drive
);

    logic pd_common;

    assign pd_common = !level;

    always_comb
    begin
        drive = '0;
        drive.input_buffer_power_enable = !power_down || WAKE_PIN;
        if (ANALOG_PIN && comparator_enable)
            drive.input_buffer_power_enable = 1'b0;
        if (CMP_PIN)
        begin
            drive.strong_up = comparator_out;
            drive.pull_down = !comparator_out;
        end
        else
        begin
            case (mode)
                ppm_pkg::PPM_QUASI:
                begin
                    drive.vweak_up = level;
                    drive.weak_up = level && pin_high;
                    drive.strong_up = level && !level_prev;
                    drive.pull_down = pd_common;
                end
                ppm_pkg::PPM_PUSH_PULL:
                begin
                    drive.strong_up = level;
                    drive.pull_down = pd_common;
                end
                ppm_pkg::PPM_OPEN_DRAIN:
                begin
                    drive.pull_down = pd_common;
                end
                ppm_pkg::PPM_INPUT_ONLY:
                begin
                    drive.pull_down = 1'b0;
                end
                default:
                begin
                    drive.pull_down = 1'b0;
                end
            endcase
        end
    end

endmodule : ppm_pin_cell

/* ppm_pin_model.sv */
// External circuitry on the fifteen port pins.
// Assumes drive structs come from the port logic; an undriven, unpulled pin toggles each cycle.
module ppm_pin_model (
    // Clock
    input wire logic ref_clk,
    // Bench drive per pin
    input wire logic [14:0] ext_en,
    input wire logic [14:0] ext_val,
    // Device drivers
    input wire ppm_pkg::ppm_drive_t [14:0] drive,
    // Resolved pin levels
    output logic [14:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [14:0] float_reg = 15'h0000;

    // A floating pin must never look like a held level
    always_ff @(posedge ref_clk)
    begin
        float_reg <= ~float_reg;
    end

    always_comb
    begin
        for (int i = 0; i < 15; i++)
        begin
            if (ext_en[i])
                pin[i] = ext_val[i];
            else if (drive[i].pull_down)
                pin[i] = 1'b0;
            else if (drive[i].strong_up | drive[i].weak_up | drive[i].vweak_up)
                pin[i] = 1'b1;
            else
                pin[i] = float_reg[i];
        end
    end
endmodule : ppm_pin_model

/* ppm_port_pin_mode_logic_tb.sv */
// Self-checking bench for the port pin mode logic with an external pin model.
// Assumes the port logic of the design package and the pin model beside it.
module ppm_port_pin_mode_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic port_wr_en = 1'b0, port_wr_sel = 1'b0, mode_wr_en = 1'b0, mode_wr_sel = 1'b0;
    logic [7:0] port_wr_data = 8'h00, mode_wr_bit_a = 8'h00, mode_wr_bit_b = 8'h00;
    logic rd_en = 1'b0, rd_sel = 1'b0, rd_rmw = 1'b0, rd_valid;
    logic power_down = 1'b0, comparator_enable = 1'b0, comparator_out = 1'b0;
    logic [7:0] p1_alt_out = 8'hff, rd_data;
    logic [6:0] p3_alt_out = 7'h7f;
    logic [14:0] ext_en = 15'h7fff, ext_val = 15'h0000, pins, port_sh, ma_sh, mb_sh;
    logic [14:0] pin_mode_bit_a, pin_mode_bit_b;
    ppm_pkg::ppm_alt_in_t alt_in;
    ppm_pkg::ppm_drive_t [7:0] p1_drive;
    ppm_pkg::ppm_drive_t [6:0] p3_drive;
    ppm_pkg::ppm_drive_t [14:0] drv;
    logic [7:0] rdq[$];
    int fail_count = 0, compares = 0;

    assign drv = {p3_drive, p1_drive};

    ppm_port_pin_mode_logic dut (.ref_clk(ref_clk), .rst(rst), .port_wr_en(port_wr_en),
        .port_wr_sel(port_wr_sel), .port_wr_data(port_wr_data), .mode_wr_en(mode_wr_en),
        .mode_wr_sel(mode_wr_sel), .mode_wr_bit_a(mode_wr_bit_a), .mode_wr_bit_b(mode_wr_bit_b),
        .rd_en(rd_en), .rd_sel(rd_sel), .rd_rmw(rd_rmw), .rd_data(rd_data), .rd_valid(rd_valid),
        .power_down(power_down), .comparator_enable(comparator_enable),
        .comparator_out(comparator_out), .p1_alt_out(p1_alt_out), .p3_alt_out(p3_alt_out),
        .alt_in(alt_in), .p1_pin_in(pins[7:0]), .p3_pin_in(pins[14:8]), .p1_drive(p1_drive),
        .p3_drive(p3_drive), .pin_mode_bit_a(pin_mode_bit_a), .pin_mode_bit_b(pin_mode_bit_b));

    ppm_pin_model model (.ref_clk(ref_clk), .ext_en(ext_en), .ext_val(ext_val), .drive(drv), .pin(pins));

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    task automatic check(string name, int idx, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s[%0d] expected %h seen %h", name, idx, e, g);
        end
    endtask : check

    // Writes both ports and both mode vectors on two back-to-back edges
    task automatic write_all(logic [14:0] p, logic [14:0] a, logic [14:0] b);
        port_sh = p;
        ma_sh = a;
        mb_sh = b;
        port_wr_en = 1'b1;
        mode_wr_en = 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            port_wr_sel = s[0];
            mode_wr_sel = s[0];
            port_wr_data = s[0] ? {1'b0, p[14:8]} : p[7:0];
            mode_wr_bit_a = s[0] ? {1'b0, a[14:8]} : a[7:0];
            mode_wr_bit_b = s[0] ? {1'b0, b[14:8]} : b[7:0];
            step(1);
        end
        port_wr_en = 1'b0;
        mode_wr_en = 1'b0;
    endtask : write_all

    function automatic ppm_pkg::ppm_drive_t exp_drv(int i, logic [1:0] m, logic lv, logic pin);
        ppm_pkg::ppm_drive_t d;
        d = '0;
        d.input_buffer_power_enable = !(power_down && i != 10 && i != 11) && !(comparator_enable && i < 2);
        if (i == 14)
        begin
            d.strong_up = comparator_out;
            d.pull_down = !comparator_out;
        end
        else if (m == ppm_pkg::PPM_QUASI)
        begin
            d.vweak_up = lv;
            d.weak_up = lv & pin;
            d.pull_down = !lv;
        end
        else if (m == ppm_pkg::PPM_PUSH_PULL)
        begin
            d.strong_up = lv;
            d.pull_down = !lv;
        end
        else if (m == ppm_pkg::PPM_OPEN_DRAIN)
            d.pull_down = !lv;
        return d;
    endfunction : exp_drv

    // Steady-state check of mode readback, every pin drive and, outside power-down and comparator enable, the peripheral inputs
    task automatic check_all();
        logic [14:0] x;
        logic [4:0] mk;
        logic [14:0] alt;
        ppm_pkg::ppm_drive_t e;
        x = pins & port_sh;
        alt = {p3_alt_out, p1_alt_out};
        check("mode_a", 0, 16'(ma_sh[13:0]), 16'(pin_mode_bit_a[13:0]));
        check("mode_b", 0, 16'(mb_sh[13:0]), 16'(pin_mode_bit_b[13:0]));
        for (int i = 0; i < 15; i++)
        begin
            e = exp_drv(i, {ma_sh[i], mb_sh[i]}, port_sh[i] & alt[i], pins[i]);
            mk = {1'b1, e.input_buffer_power_enable, 2'b11, i != 14};
            check("drive", i, 16'(e & mk), 16'(drv[i] & mk));
        end
        if (!power_down && !comparator_enable)
            check("alt_in", 0, 16'({x[0], x[1], x[4], x[5], x[6], x[7], x[8], x[10], x[11], x[12], x[13]}),
                16'(alt_in));
    endtask : check_all

    task automatic chk_strong(logic [14:0] e);
        logic [14:0] g;
        for (int i = 0; i < 15; i++)
            g[i] = drv[i].strong_up;
        check("strong_up", 0, 16'(e), 16'(g));
    endtask : chk_strong

    // Four back-to-back reads: every port with plain and read-modify-write
    task automatic reads4();
        rd_en = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            rd_sel = k[1];
            rd_rmw = k[0];
            rdq.push_back(k[0] ? (k[1] ? {1'b0, port_sh[14:8]} : port_sh[7:0])
                : (k[1] ? {1'b0, pins[14:8]} : pins[7:0]));
            step(1);
        end
        rd_en = 1'b0;
        step(2);
    endtask : reads4

    always @(negedge ref_clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (rdq.size() == 0)
                check("rd_valid", 0, 16'h0000, 16'h0001);
            else
                check("rd_data", 0, 16'(rdq.pop_front()), 16'(rd_data));
        end
    end

    initial
    begin
        logic [14:0] a;
        logic [14:0] b;
        port_sh = ppm_pkg::PORT_RESET;
        ma_sh = ppm_pkg::MODE_A_RESET;
        mb_sh = ppm_pkg::MODE_B_RESET;
        void'($urandom(25751));
        step(6);
        rst = 1'b0;
        step(3);
        check("mode_a_rst", 0, 16'h7fff, 16'(pin_mode_bit_a));
        check_all();
        $display("test reset done");
        for (int n = 0; n < 30; n++)
        begin
            power_down = ($urandom % 4) == 0;
            comparator_enable = ($urandom % 3) == 0;
            comparator_out = 1'($urandom);
            p1_alt_out = 8'($urandom);
            p3_alt_out = 7'($urandom);
            ext_val = 15'($urandom);
            a = 15'($urandom);
            b = 15'($urandom);
            if (comparator_enable)
            begin
                a[1:0] = 2'b11;
                b[1:0] = 2'b00;
            end
            write_all(15'($urandom), a, b);
            step(6);
            check_all();
        end
        $display("test random modes done");
        power_down = 1'b0;
        comparator_enable = 1'b0;
        comparator_out = 1'b0;
        p1_alt_out = 8'hff;
        p3_alt_out = 7'h7f;
        write_all(15'h0000, 15'h0000, 15'h0000);
        step(4);
        write_all(15'h7fff, 15'h0000, 15'h0000);
        chk_strong(15'h00ff);
        step(1);
        chk_strong(15'h3f00);
        step(1);
        chk_strong(15'h0000);
        $display("test strong pulse done");
        ext_val = 15'($urandom);
        write_all(15'($urandom), 15'h7fff, 15'h0000);
        step(4);
        reads4();
        // port bits set for alternate use
        ext_en = 15'h0000;
        write_all(15'h7fff, 15'h0000, 15'h0000);
        step(6);
        check_all();
        reads4();
        check("rd_queue", 0, 16'h0000, 16'(rdq.size()));
        $display("test reads done");
        final_report();
    end

    // The whole run takes well under 1000 cycles
    initial
    begin
        #20000;
        fail_count++;
        final_report();
    end
endmodule : ppm_port_pin_mode_logic_tb
